// *** hdl/ufc_map.vh ***
// Purpose: Register map and field constants for the serial port configuration block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Printed offsets are indices; byte address is four times the index
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define UFC_IDX_FORMAT    8'h07
`define UFC_IDX_BAUD_LO   8'h08
`define UFC_IDX_BAUD_HI   8'h09
`define UFC_IDX_ABW       8'h0a
`define UFC_IDX_DBG       8'h0b
`define UFC_IDX_EVI       8'h0c
`define UFC_IDX_INFRARED_TX_PULSE_SETTING      8'h0d
`define UFC_IDX_FRAME     8'h10
`define UFC_IDX_STATUS    8'h11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UFC_RST_FORMAT    8'h03
`define UFC_RST_ZERO8     8'h00

// ----------------------------------------
// Communication modes
// ----------------------------------------
`define UFC_MODE_ASYNC    2'h0
`define UFC_MODE_SYNC     2'h1
`define UFC_MODE_IR       2'h2
`define UFC_MODE_SPI      2'h3

// ----------------------------------------
// Parity codes
// ----------------------------------------
`define UFC_PAR_OFF       2'h0
`define UFC_PAR_EVEN      2'h2
`define UFC_PAR_ODD       2'h3

// ----------------------------------------
// Character sizes
// ----------------------------------------
`define UFC_CH_9L         3'h6
`define UFC_CH_9H         3'h7
`define UFC_CH_BASE       4'h5

// ----------------------------------------
// Pulse shaping
// ----------------------------------------
`define UFC_INFRARED_TX_PULSE_SETTING_3_16     8'h00
`define UFC_INFRARED_TX_PULSE_SETTING_PASS     8'hff
`define UFC_SIXTEENTHS    4'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UFC_F_MODE        7:6
`define UFC_F_PAR         5:4
`define UFC_F_STOP        3
`define UFC_F_CHSZ        2:0
`define UFC_F_ORDER       2
`define UFC_F_PHASE       1
`define UFC_F_ABW         7:6
`define UFC_F_BIT0        0

`endif

// *** hdl/ufc_top.v ***
// Purpose: Frame format, baud divisor and infrared configuration with IR pulse shaper
// Assumes: APB slave at 50 MHz, synchronous active-high reset, inputs synchronous
// Notes:   Datapaths outside; this block decodes the settings and shapes IR pulses
//
// Overview of operation
// R1: Two-bit field selects communication mode
// R2: SPI mode remaps format register bits
// R3: Transmitter sends computed parity when enabled
// R4: Receiver flags parity mismatch
// R5: Stop bits one or two, transmit only
// R6: Shared character size, 5 to 9 bits
// R7: SPI bit order MSB or LSB first
// R8: Order change mid-transfer corrupts transfer
// R9: SPI clock phase selects sample edge
// R10: Baud divisor as two byte registers
// R11: Divisor write reloads prescaler immediately
// R12: Auto-baud tolerance window two-bit field
// R13: Halted debug stops port unless run bit
// R14: IR event input replaces receive pin
// R15: Pulse setting zero gives 3/16 period
// R16: Other settings give N-clock pulses at baud edge
// R17: Setting 0xff passes signals unaltered
// R18: Software sets pulse before transmitter enable
// R19: Auto-baud only in asynchronous slave operation
// R20: Software avoids reserved parity and size codes
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "ufc_map.vh"

module ufc_top (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        srst_in,
   // APB
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   // Frame datapath hooks
   input  wire [8:0]  tx_data_in,
   input  wire [8:0]  rx_data_in,
   input  wire        rx_parity_bit_in,
   input  wire        rx_check_in,
   input  wire        busy_in,
   input  wire        autobaud_req_in,
   input  wire        cpu_halted_in,
   // Infrared path
   input  wire        baud_tick_in,
   input  wire        tx_bit_in,
   input  wire        rx_pin_in,
   input  wire        rx_event_in,
   // Decoded settings
   output reg  [1:0]  comm_mode_select_out,
   output reg         tx_parity_bit_out,
   output reg         parity_error_flag_out,
   output reg  [1:0]  stop_bit_count_out,
   output reg  [3:0]  character_width_out,
   output reg         nine_bit_high_first_out,
   output reg         spi_bit_order_out,
   output reg         spi_sample_edge_out,
   output reg         corrupt_out,
   output reg  [15:0] baud_divisor_out,
   output reg         prescaler_reload_out,
   output reg  [1:0]  autobaud_tolerance_out,
   output reg         autobaud_allow_out,
   output reg         port_run_out,
   output reg         ir_rx_out,
   output reg         ir_tx_out
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg  [7:0]  frame_format_control;
reg  [15:0] baud_divisor;
reg  [7:0]  autobaud_window_control;
reg  [7:0]  debug_run_control;
reg  [7:0]  infrared_event_input_control;
reg  [7:0]  infrared_tx_pulse_length;
reg  [7:0]  pulse_cnt;
reg  [3:0]  sub_cnt;
reg         pulse_on;

wire        wr_en     = psel_in & penable_in & pwrite_in;
wire [7:0]  idx       = paddr_in[9:2];
wire        addr_ok   = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
wire [1:0]  mode      = frame_format_control[`UFC_F_MODE];
wire        is_spi    = (mode == `UFC_MODE_SPI);
wire [1:0]  par       = frame_format_control[`UFC_F_PAR];
wire [2:0]  chsz      = frame_format_control[`UFC_F_CHSZ];
wire        run       = ~cpu_halted_in | debug_run_control[`UFC_F_BIT0];
reg         mapped;
reg  [31:0] next_rdata;
reg  [8:0]  tx_mask;
reg         tx_xor;
reg         rx_xor;

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
   mapped     = addr_ok;
   next_rdata = 32'h0;
   case (idx)
      `UFC_IDX_FORMAT:  next_rdata = {24'h0, frame_format_control};
      `UFC_IDX_BAUD_LO: next_rdata = {24'h0, baud_divisor[7:0]};               // [R10]
      `UFC_IDX_BAUD_HI: next_rdata = {24'h0, baud_divisor[15:8]};              // [R10]
      `UFC_IDX_ABW:     next_rdata = {24'h0, autobaud_window_control};
      `UFC_IDX_DBG:     next_rdata = {24'h0, debug_run_control};
      `UFC_IDX_EVI:     next_rdata = {24'h0, infrared_event_input_control};
      `UFC_IDX_INFRARED_TX_PULSE_SETTING:    next_rdata = {24'h0, infrared_tx_pulse_length};
      `UFC_IDX_STATUS:  next_rdata = {29'h0, pulse_on, corrupt_out, parity_error_flag_out};
      default:          mapped = 1'b0;
   endcase
end

// ----------------------------------------
// Parity over active data bits
// ----------------------------------------
always @* begin
   case (chsz)
      3'h0:    tx_mask = 9'h01f;
      3'h1:    tx_mask = 9'h03f;
      3'h2:    tx_mask = 9'h07f;
      3'h3:    tx_mask = 9'h0ff;
      default: tx_mask = 9'h1ff;
   endcase
   tx_xor = ^(tx_data_in & tx_mask) ^ (par == `UFC_PAR_ODD);                    // [R3]
   rx_xor = ^(rx_data_in & tx_mask) ^ (par == `UFC_PAR_ODD) ^ rx_parity_bit_in; // [R4]
end

// ----------------------------------------
// APB slave and register writes
// ----------------------------------------
always @(posedge ref_clk_in) begin
   if (srst_in) begin
      frame_format_control         <= `UFC_RST_FORMAT;
      baud_divisor                 <= 16'h0;
      autobaud_window_control      <= `UFC_RST_ZERO8;
      debug_run_control            <= `UFC_RST_ZERO8;
      infrared_event_input_control <= `UFC_RST_ZERO8;
      infrared_tx_pulse_length     <= `UFC_RST_ZERO8;
      prdata_out                   <= 32'h0;
      pready_out                   <= 1'b0;
      pslverr_out                  <= 1'b0;
      prescaler_reload_out         <= 1'b0;
      corrupt_out                  <= 1'b0;
      parity_error_flag_out        <= 1'b0;
   end else begin
      pready_out           <= psel_in & ~penable_in;
      pslverr_out          <= psel_in & ~penable_in & ~mapped;
      prdata_out           <= (psel_in & ~penable_in & ~pwrite_in & mapped) ? next_rdata : 32'h0;
      prescaler_reload_out <= 1'b0;
      if (wr_en & pready_out & mapped) begin
         case (idx)
            `UFC_IDX_FORMAT: begin
               frame_format_control <= pwdata_in[7:0];                       // [R1]
               if (is_spi && busy_in &&
                   (pwdata_in[`UFC_F_ORDER] != frame_format_control[`UFC_F_ORDER]))
                  corrupt_out <= 1'b1;                                       // [R8]
            end
            `UFC_IDX_BAUD_LO: begin
               baud_divisor[7:0]    <= pwdata_in[7:0];                        // [R10]
               prescaler_reload_out <= 1'b1;                                  // [R11]
               if (busy_in)
                  corrupt_out <= 1'b1;                                       // [R11]
            end
            `UFC_IDX_BAUD_HI: begin
               baud_divisor[15:8]   <= pwdata_in[7:0];                        // [R10]
               prescaler_reload_out <= 1'b1;                                  // [R11]
               if (busy_in)
                  corrupt_out <= 1'b1;                                       // [R11]
            end
            `UFC_IDX_ABW:  autobaud_window_control      <= pwdata_in[7:0];    // [R12]
            `UFC_IDX_DBG:  debug_run_control            <= pwdata_in[7:0];    // [R13]
            `UFC_IDX_EVI:  infrared_event_input_control <= pwdata_in[7:0];    // [R14]
            `UFC_IDX_INFRARED_TX_PULSE_SETTING: infrared_tx_pulse_length     <= pwdata_in[7:0];    // [R18]
            `UFC_IDX_STATUS: begin
               if (pwdata_in[0])
                  parity_error_flag_out <= 1'b0;
               if (pwdata_in[1])
                  corrupt_out <= 1'b0;
            end
            default: ;
         endcase
      end
      // Set wins over clear
      if (rx_check_in && run && !is_spi && par != `UFC_PAR_OFF && rx_xor)
         parity_error_flag_out <= 1'b1;                                      // [R4]
   end
end

// ----------------------------------------
// Decoded settings
// ----------------------------------------
always @(posedge ref_clk_in) begin
   if (srst_in) begin
      comm_mode_select_out    <= `UFC_MODE_ASYNC;
      tx_parity_bit_out       <= 1'b0;
      stop_bit_count_out      <= 2'h1;
      character_width_out     <= 4'h8;
      nine_bit_high_first_out <= 1'b0;
      spi_bit_order_out       <= 1'b0;
      spi_sample_edge_out     <= 1'b0;
      baud_divisor_out        <= 16'h0;
      autobaud_tolerance_out  <= 2'h0;
      autobaud_allow_out      <= 1'b0;
      port_run_out            <= 1'b1;
   end else begin
      comm_mode_select_out    <= mode;                                              // [R1]
      tx_parity_bit_out       <= (!is_spi && par != `UFC_PAR_OFF) ? tx_xor : 1'b0;  // [R3]
      stop_bit_count_out      <= is_spi ? 2'h1 :
                                 (frame_format_control[`UFC_F_STOP] ? 2'h2 : 2'h1); // [R5]
      character_width_out     <= is_spi ? 4'h8 :
                                 (chsz[2] ? 4'h9 : `UFC_CH_BASE + {2'h0, chsz[1:0]}); // [R6]
      nine_bit_high_first_out <= !is_spi && (chsz == `UFC_CH_9H);                   // [R6]
      spi_bit_order_out       <= is_spi & frame_format_control[`UFC_F_ORDER];       // [R2] [R7]
      spi_sample_edge_out     <= is_spi & frame_format_control[`UFC_F_PHASE];       // [R2] [R9]
      baud_divisor_out        <= baud_divisor;
      autobaud_tolerance_out  <= autobaud_window_control[`UFC_F_ABW];               // [R12]
      autobaud_allow_out      <= autobaud_req_in && (mode == `UFC_MODE_ASYNC);      // [R19]
      port_run_out            <= run;                                               // [R13]
   end
end

// ----------------------------------------
// Infrared pulse shaper
// ----------------------------------------
wire is_ir  = (mode == `UFC_MODE_IR);
wire pass   = ~is_ir | (infrared_tx_pulse_length == `UFC_INFRARED_TX_PULSE_SETTING_PASS);
wire rx_src = (is_ir & infrared_event_input_control[`UFC_F_BIT0]) ? rx_event_in : rx_pin_in; // [R14]

always @(posedge ref_clk_in) begin
   if (srst_in) begin
      pulse_cnt <= 8'h0;
      sub_cnt   <= 4'h0;
      pulse_on  <= 1'b0;
      ir_tx_out <= 1'b1;
      ir_rx_out <= 1'b1;
   end else begin
      ir_rx_out <= run ? rx_src : ir_rx_out;                                        // [R13]
      if (pass) begin
         pulse_on  <= 1'b0;
         pulse_cnt <= 8'h0;
         sub_cnt   <= 4'h0;
         ir_tx_out <= tx_bit_in;                                                    // [R17] [R18]
      end else if (baud_tick_in && !pulse_on && !tx_bit_in && run) begin
         pulse_on  <= 1'b1;
         sub_cnt   <= 4'h0;
         pulse_cnt <= 8'h1;
         ir_tx_out <= 1'b1;                                                         // [R16]
      end else if (pulse_on) begin
         if (infrared_tx_pulse_length == `UFC_INFRARED_TX_PULSE_SETTING_3_16) begin
            if (baud_tick_in)
               sub_cnt <= sub_cnt + 4'h1;
            if (baud_tick_in && sub_cnt == `UFC_SIXTEENTHS - 4'h1) begin
               pulse_on  <= 1'b0;
               ir_tx_out <= 1'b0;                                                   // [R15]
            end
         end else begin
            pulse_cnt <= pulse_cnt + 8'h1;
            if (pulse_cnt >= infrared_tx_pulse_length) begin
               pulse_on  <= 1'b0;
               ir_tx_out <= 1'b0;                                                   // [R16]
            end
         end
      end else begin
         ir_tx_out <= 1'b0;
      end
   end
end

endmodule // ufc_top

// *** test/ufc_checker.sv ***
// Purpose: Port assertions for the serial configuration block
// Assumes: Byte address is four times the register index
// Notes:   Shadows the pulse setting to judge pulse widths
`timescale 1ns/1ps
module ufc_checker (
   // Clock, reset and bus
   input wire        ref_clk_in,
   input wire        srst_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire        pready_out,
   // Settings and infrared
   input wire        baud_tick_in,
   input wire [1:0]  comm_mode_select_out,
   input wire [1:0]  stop_bit_count_out,
   input wire        spi_bit_order_out,
   input wire [15:0] baud_divisor_out,
   input wire        prescaler_reload_out,
   input wire [1:0]  autobaud_tolerance_out,
   input wire        autobaud_allow_out,
   input wire        ir_tx_out
);
   reg  [7:0]  pl;
   reg  [15:0] hi;
   reg         arm;
   wire        wr = psel_in & penable_in & pready_out & pwrite_in;
   wire        irm = comm_mode_select_out == 2'h2;
   wire        fmt = wr && paddr_in == 12'h01c;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // ----------------------------------------
   // Pulse setting shadow and high-time count
   // ----------------------------------------
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         pl  <= 8'h00;
         hi  <= 16'h0000;
         arm <= 1'b0;
      end else begin
         if (wr && paddr_in == 12'h034)
            pl <= pwdata_in[7:0];
         hi <= ir_tx_out ? hi + 16'h0001 : 16'h0000;
         if (ir_tx_out && hi == 16'h0000)
            arm <= irm;
      end
   end
   apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no answer after setup");
   mode_write_a: assert property (fmt |-> ##2 comm_mode_select_out == $past(pwdata_in[7:6], 2))
      else $error("mode not taken");
   stop_count_a: assert property (fmt && pwdata_in[7:6] != 2'h3 |-> ##2
      stop_bit_count_out == 2'h1 + {1'b0, $past(pwdata_in[3], 2)}) else $error("stop count wrong");
   bit_order_a: assert property (fmt && pwdata_in[7:6] == 2'h3 |-> ##2
      spi_bit_order_out == $past(pwdata_in[2], 2)) else $error("bit order wrong");
   baud_low_a: assert property (wr && paddr_in == 12'h020 |-> ##2
      baud_divisor_out[7:0] == $past(pwdata_in[7:0], 2)) else $error("divisor low byte wrong");
   baud_reload_a: assert property (wr && (paddr_in == 12'h020 || paddr_in == 12'h024)
      |=> prescaler_reload_out) else $error("no prescaler reload");
   window_write_a: assert property (wr && paddr_in == 12'h028 |-> ##2
      autobaud_tolerance_out == $past(pwdata_in[7:6], 2)) else $error("window wrong");
   autobaud_async_a: assert property (comm_mode_select_out != 2'h0 [*2] |-> !autobaud_allow_out)
      else $error("autobaud outside async");
   pulse_start_a: assert property ($rose(ir_tx_out) && irm && pl != 8'hff |-> $past(baud_tick_in))
      else $error("pulse not on baud edge");
   pulse_length_a: assert property ($fell(ir_tx_out) && arm && irm && pl != 8'h00 && pl != 8'hff
      |-> hi == {8'h00, pl}) else $error("pulse length wrong");
   cover property (fmt && pwdata_in[7:6] == 2'h3);
   cover property ($fell(ir_tx_out) && arm);
   cover property (prescaler_reload_out);
endmodule // ufc_checker

bind ufc_top ufc_checker ufc_checker_i (.ref_clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .pwdata_in, .pready_out, .baud_tick_in, .comm_mode_select_out, .stop_bit_count_out, .spi_bit_order_out,
   .baud_divisor_out, .prescaler_reload_out, .autobaud_tolerance_out, .autobaud_allow_out, .ir_tx_out);

// *** test/ufc_ir_peer.sv ***
// Purpose: Infrared transceiver on the far side of the port
// Assumes: Pulses are active high on the light output of the port
// Notes:   Reports the width of the last pulse in clock cycles
`timescale 1ns/1ps
module ufc_ir_peer (
   // Clock and light from the port
   input  wire        ref_clk_in,
   input  wire        ir_tx_in,
   // Pulse width and light toward the port
   output reg  [15:0] pulse_width_out = 16'h0000,
   output reg         light_out = 1'b1
);
   reg [15:0] run = 16'h0000;
   always @(posedge ref_clk_in) begin
      run <= ir_tx_in ? run + 16'h0001 : 16'h0000;
      if (!ir_tx_in && run != 16'h0000)
         pulse_width_out <= run;
      light_out <= ~ir_tx_in;
   end
endmodule // ufc_ir_peer

// *** test/tb.sv ***
// Purpose: Self-checking bench for the serial configuration block
// Assumes: 50 MHz clock, APB master by tasks
// Notes:   One task per scenario
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   reg         ref_clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, err;
   reg  [11:0] paddr_in = 12'h000;
   reg  [31:0] pwdata_in = 32'h0, rd;
   reg  [8:0]  tx_data_in = 9'h007, rx_data_in = 9'h007;
   reg         rx_parity_bit_in = 1'b0, rx_check_in = 1'b0, busy_in = 1'b0, autobaud_req_in = 1'b0;
   reg         cpu_halted_in = 1'b0, baud_tick_in = 1'b0, tx_bit_in = 1'b1, rx_event_in = 1'b0;
   wire        rx_pin_in, pready_out, pslverr_out, tx_parity_bit_out, parity_error_flag_out;
   wire        nine_bit_high_first_out, spi_bit_order_out, spi_sample_edge_out, corrupt_out;
   wire        prescaler_reload_out, autobaud_allow_out, port_run_out, ir_rx_out, ir_tx_out;
   wire [31:0] prdata_out;
   wire [15:0] baud_divisor_out, width;
   wire [3:0]  character_width_out;
   wire [1:0]  comm_mode_select_out, stop_bit_count_out, autobaud_tolerance_out;
   int         error_cnt = 0, checks = 0, i, j;
   ufc_top ufc_top_i (.ref_clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .tx_data_in, .rx_data_in, .rx_parity_bit_in, .rx_check_in,
      .busy_in, .autobaud_req_in, .cpu_halted_in, .baud_tick_in, .tx_bit_in, .rx_pin_in, .rx_event_in,
      .comm_mode_select_out, .tx_parity_bit_out, .parity_error_flag_out, .stop_bit_count_out,
      .character_width_out, .nine_bit_high_first_out, .spi_bit_order_out, .spi_sample_edge_out, .corrupt_out,
      .baud_divisor_out, .prescaler_reload_out, .autobaud_tolerance_out, .autobaud_allow_out, .port_run_out,
      .ir_rx_out, .ir_tx_out);
   ufc_ir_peer ufc_ir_peer_i (.ref_clk_in, .ir_tx_in(ir_tx_out), .pulse_width_out(width), .light_out(rx_pin_in));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task conclude;
      $display("Comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task xfer(input reg w, input [11:0] a, input [31:0] d);
      int n;
      n = 0;
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do @(posedge ref_clk_in); while (pready_out !== 1'b1 && ++n < 20);
      if (pready_out !== 1'b1)
         error_cnt++;
      rd = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'b00;
      @(posedge ref_clk_in);
   endtask
   task wr(input [11:0] a, input [31:0] d);
      xfer(1'b1, a, d);
      repeat (3) @(posedge ref_clk_in);
   endtask
   task rchk(input [11:0] a, input [7:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK("read", {24'h0, e}, rd)
   endtask
   task pulse(input int gap);
      tx_bit_in <= 1'b0;
      repeat (4) begin
         baud_tick_in <= 1'b1;
         @(posedge ref_clk_in);
         baud_tick_in <= 1'b0;
         repeat (gap - 1) @(posedge ref_clk_in);
      end
      tx_bit_in <= 1'b1;
      repeat (20) @(posedge ref_clk_in);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      `CHK("stops", 2'h1, stop_bit_count_out)
      `CHK("size", 4'h8, character_width_out)
      rchk(12'h01c, 8'h03);
      for (i = 8; i < 14; i++)
         rchk(12'(i * 4), 8'h00);
      xfer(1'b0, 12'h040, 32'h0);
      `CHK("unmapped", 1'b1, err)
   endtask
   task t_format;
      reg [1:0] pm;
      for (i = 0; i < 8; i++)
         for (j = 0; j < 3; j++)
            if (i < 4 || i > 5) begin
               pm = (j == 0) ? 2'h0 : 2'(j + 1);
               wr(12'h01c, {26'h0, pm, i[0], i[2:0]});
               `CHK("mode", 2'h0, comm_mode_select_out)
               `CHK("size", (i < 4) ? 4'(i + 5) : 4'h9, character_width_out)
               `CHK("high first", i == 7, nine_bit_high_first_out)
               `CHK("stops", 2'h1 + 2'(i[0]), stop_bit_count_out)
               `CHK("tx parity", pm == 2'h2, tx_parity_bit_out)
               rx_check_in <= 1'b1;
               @(posedge ref_clk_in);
               rx_check_in <= 1'b0;
               repeat (3) @(posedge ref_clk_in);
               `CHK("parity error", pm == 2'h2, parity_error_flag_out)
               wr(12'h044, 32'h1);
               `CHK("cleared", 1'b0, parity_error_flag_out)
            end
   endtask
   task t_spi;
      wr(12'h01c, 32'he6);
      `CHK("mode", 2'h3, comm_mode_select_out)
      `CHK("order", 1'b1, spi_bit_order_out)
      `CHK("phase", 1'b1, spi_sample_edge_out)
      `CHK("spi parity", 1'b0, tx_parity_bit_out)
      busy_in <= 1'b1;
      wr(12'h01c, 32'he2);
      busy_in <= 1'b0;
      `CHK("order", 1'b0, spi_bit_order_out)
      `CHK("corrupt", 1'b1, corrupt_out)
      wr(12'h044, 32'h2);
      `CHK("corrupt", 1'b0, corrupt_out)
   endtask
   task t_baud;
      wr(12'h020, 32'h34);
      busy_in <= 1'b1;
      wr(12'h024, 32'h12);
      busy_in <= 1'b0;
      `CHK("divisor", 16'h1234, baud_divisor_out)
      `CHK("corrupt", 1'b1, corrupt_out)
      xfer(1'b1, 12'h021, 32'hff);
      `CHK("misaligned", 1'b1, err)
      rchk(12'h024, 8'h12);
   endtask
   task t_abw;
      autobaud_req_in <= 1'b1;
      wr(12'h01c, 32'h03);
      for (i = 0; i < 4; i++) begin
         wr(12'h028, 32'(i) << 6);
         `CHK("window", 2'(i), autobaud_tolerance_out)
         `CHK("autobaud", 1'b1, autobaud_allow_out)
      end
      wr(12'h01c, 32'h43);
      `CHK("mode", 2'h1, comm_mode_select_out)
      `CHK("autobaud", 1'b0, autobaud_allow_out)
      autobaud_req_in <= 1'b0;
   endtask
   task t_dbg;
      cpu_halted_in <= 1'b1;
      wr(12'h02c, 32'h0);
      `CHK("halted", 1'b0, port_run_out)
      wr(12'h02c, 32'h1);
      `CHK("run", 1'b1, port_run_out)
      cpu_halted_in <= 1'b0;
   endtask
   task t_ir;
      wr(12'h034, 32'h5);
      wr(12'h01c, 32'h83);
      pulse(8);
      `CHK("pulse", 16'h5, width)
      wr(12'h034, 32'h0);
      pulse(4);
      `CHK("short pulse", 16'hc, width)
      wr(12'h034, 32'hff);
      tx_bit_in <= 1'b0;
      wr(12'h030, 32'h1);
      `CHK("pass", 1'b0, ir_tx_out)
      `CHK("event rx", rx_event_in, ir_rx_out)
      wr(12'h030, 32'h0);
      `CHK("pin rx", rx_pin_in, ir_rx_out)
      tx_bit_in <= 1'b1;
   endtask
   initial forever #10 ref_clk_in = ~ref_clk_in;
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      @(posedge ref_clk_in);
      t_reset;
      t_format;
      t_spi;
      t_baud;
      t_abw;
      t_dbg;
      t_ir;
      conclude;
   end
endmodule // tb
